// ===== design/rtm_pkg.sv
package rtm_pkg;

   // port count limit of the vector field and port address width
   localparam int MAX_PORTS = 16;
   localparam int PORT_W = 4;
   localparam int COUNT_W = 16;

   // register indices, byte address is four times the index
   localparam logic [5:0] IDX_PKT_INT_STATUS = 6'h0F;
   localparam logic [5:0] IDX_PAGE_AND_LOG_SUMMARY = 6'h10;
   localparam logic [5:0] IDX_REVISION_CODE = 6'h11;
   localparam logic [5:0] IDX_LOWER_COUNT_ENABLES = 6'h12;
   localparam logic [5:0] IDX_UPPER_COUNT_ENABLES = 6'h13;
   localparam logic [2:0] PAGE_ZERO = 3'h0;

   // status byte layout
   localparam int CAUSE_LSB = 0;
   localparam int PORT_NUMBER_LSB = 4;
   localparam logic [3:0] CAUSE_FIRST_COLLISION = 4'hD;
   localparam logic [3:0] CAUSE_RECEIVE = 4'hB;
   localparam logic [3:0] CAUSE_ISOLATION = 4'h7;
   localparam logic [7:0] NO_VALID_INTERRUPT = 8'hFF;

   // page and summary layout
   localparam int PAGE_SEL_LSB = 0;
   localparam int FLAG_FOUND_BIT = 4;
   localparam int SUMMARY_LSB = 4;

   // summary vector order, also order of the log interrupt disables
   localparam int SUM_FLAG_FOUND = 0;
   localparam int SUM_LOW_COUNT = 1;
   localparam int SUM_HIGH_COUNT = 2;
   localparam int SUM_FULL_COUNTER = 3;

   // upper count enable layout
   localparam int CLEAR_ON_READ_BIT = 0;
   localparam int STOP_AT_MAX_BIT = 1;
   localparam int TX_COL_BIT = 3;
   localparam int RX_COL_BIT = 4;
   localparam int OWC_BIT = 5;
   localparam logic [7:0] UPPER_WRITABLE = 8'h3B;

   // per-packet interrupt disables, high means no report
   localparam int RT_MASK_ISOLATION = 0;
   localparam int RT_MASK_COLLISION = 1;
   localparam int RT_MASK_RECEIVE = 2;

   // reset values
   localparam logic [2:0] PAGE_RESET = 3'h0;
   localparam logic [7:0] LOWER_RESET = 8'h00;
   localparam logic [7:0] UPPER_RESET = 8'h00;

   // counter thresholds
   localparam logic [15:0] LOW_THRESHOLD = 16'h00FF;
   localparam logic [15:0] HIGH_THRESHOLD = 16'hC000;
   localparam logic [15:0] FULL_VALUE = 16'hFFFF;

   // bus answers
   localparam int AXI_AW = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [0:0] {
      WR_IDLE = 1'b0,
      WR_RESP = 1'b1
   } rtm_wr_state_type;

   typedef enum logic [0:0] {
      RD_IDLE = 1'b0,
      RD_RESP = 1'b1
   } rtm_rd_state_type;

   // pending per-packet interrupt sources
   typedef struct packed {
      logic rx_pend;
      logic [3:0] rx_port;
      logic col_pend;
      logic [3:0] col_port;
      logic [MAX_PORTS-1:0] part_pend;
      logic [3:0] rr_ptr;
   } rtm_pend_type;

   // whole state of the register block
   typedef struct packed {
      rtm_wr_state_type wr_st;
      logic aw_have;
      logic [5:0] aw_idx;
      logic aw_ok;
      logic w_have;
      logic [7:0] wdata;
      logic wlane0;
      logic [1:0] bresp;
      rtm_rd_state_type rd_st;
      logic [7:0] rdata;
      logic [1:0] rresp;
      rtm_pend_type pend;
      logic [2:0] page;
      logic [7:0] lower;
      logic [7:0] upper;
      logic [3:0] summary;
      logic event_log_interrupt_pin;
      logic [2*MAX_PORTS-1:0] col_inc;
   } rtm_state_type;

endpackage

// ===== design/rtm_regs.sv
`timescale 1ns/100ps
// What this block does
// - next packet transmit discards unserviced interrupts
// - report receive, then first collision, then isolation
// - isolation reports polled around ports in rotation
// - status read clears the reported interrupt
// - cause low nibble, port address high nibble
// - one active-low cause bit per source
// - nothing pending reads as all ones
// - page bits read back and switch pages
// - page register mapped on every page
// - flag found when any unmasked latch set
// - low count when any counter below threshold
// - high count when any counter above threshold
// - full counter when any counter at maximum
// - revision code read-only, writes ignored
// - lower mask bits enable eight event counts
// - clear-on-read bit makes reads reset counters
// - stop-at-max bit freezes full counters
// - separate transmit, receive, out-of-window enables
// - out-of-window plus collision enables counts twice
// - mask bit one enables, zero disables counting
// - enabled summary conditions drive event log pin
module rtm_regs
   import rtm_pkg::*;
#(
   parameter int NUM_PORTS = 13,
   parameter logic [7:0] REVISION = 8'h02 // arbitrary value
) (
   // clock and reset
   input wire logic I_MCLK,
   input wire logic I_ARST_N,
   // axi4-lite write address and data
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [AXI_AW-1:0] I_AWADDR,
   input wire logic [2:0] I_AWPROT,
   input wire logic I_WVALID,
   output logic O_WREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   // axi4-lite write response
   output logic O_BVALID,
   input wire logic I_BREADY,
   output logic [1:0] O_BRESP,
   // axi4-lite read
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   input wire logic [AXI_AW-1:0] I_ARADDR,
   input wire logic [2:0] I_ARPROT,
   output logic O_RVALID,
   input wire logic I_RREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   // per-packet interrupt events
   input wire logic I_TX_START,
   input wire logic I_RX_EVENT,
   input wire logic [3:0] I_RX_PORT,
   input wire logic I_FIRST_COL_EVENT,
   input wire logic [3:0] I_COL_PORT,
   input wire logic [NUM_PORTS-1:0] I_ISOLATION_EVENT,
   input wire logic [2:0] I_RT_INT_DISABLE,
   // event logging state from the port counters and latches
   input wire logic [NUM_PORTS-1:0] I_PORT_FLAG_SET,
   input wire logic [NUM_PORTS*COUNT_W-1:0] I_EVENT_COUNT,
   input wire logic [3:0] I_ELI_DISABLE,
   // collision events per port
   input wire logic [NUM_PORTS-1:0] I_TX_COL,
   input wire logic [NUM_PORTS-1:0] I_RX_COL,
   input wire logic [NUM_PORTS-1:0] I_OWC,
   // configuration towards the counters
   output logic [2:0] O_PAGE_SEL,
   output logic [7:0] O_LOWER_COUNT_EN,
   output logic O_CLEAR_COUNTER_ON_READ,
   output logic O_STOP_COUNTER_AT_MAX,
   output logic [2*NUM_PORTS-1:0] O_COL_COUNT_INC,
   // status pins
   output logic O_PKT_INT_PENDING,
   output logic O_EVENT_LOG_INTERRUPT_PIN
);

   // refuse port counts that the vectors cannot hold
   if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS) begin : g_bad_ports
      $error("rtm_regs: NUM_PORTS out of range");
   end

   rtm_state_type s_q;
   rtm_state_type s_d;
   logic rr_valid;
   logic [3:0] rr_idx;
   logic [NUM_PORTS-1:0] part_req;

   // true when an index answers on the given page
   function automatic logic reg_hit(input logic [5:0] idx,
                                    input logic [2:0] page);
      reg_hit = 1'b0;
      if (idx == IDX_PKT_INT_STATUS) begin
         reg_hit = 1'b1;
      end else if (idx == IDX_PAGE_AND_LOG_SUMMARY) begin
         reg_hit = 1'b1;
      end else if (page == PAGE_ZERO) begin
         if (idx == IDX_REVISION_CODE) begin
            reg_hit = 1'b1;
         end else if (idx == IDX_LOWER_COUNT_ENABLES) begin
            reg_hit = 1'b1;
         end else if (idx == IDX_UPPER_COUNT_ENABLES) begin
            reg_hit = 1'b1;
         end
      end
   endfunction

   // word index of a byte address, valid only when aligned
   function automatic logic [6:0] addr_decode(
      input logic [AXI_AW-1:0] addr);
      addr_decode = {addr[1:0] == 2'b00, addr[7:2]};
   endfunction

   // status byte from a cause and a port
   function automatic logic [7:0] status_byte(input logic [3:0] cause,
                                              input logic [3:0] port);
      status_byte = 8'h00;
      status_byte[CAUSE_LSB +: 4] = cause;
      status_byte[PORT_NUMBER_LSB +: 4] = port;
   endfunction

   assign part_req = s_q.pend.part_pend[NUM_PORTS-1:0];

   // rotating pick among isolation reports
   rtm_rr_pick #(
      .N(NUM_PORTS)
   ) u_pick (
      .i_req(part_req),
      .i_ptr(s_q.pend.rr_ptr),
      .o_valid(rr_valid),
      .o_idx(rr_idx)
   );

   // next state
   always_comb begin
      logic aw_ok;
      logic w_ok;
      logic [6:0] dec;
      logic [5:0] widx;
      logic [7:0] rd;
      logic [4:0] nxt;
      logic [COUNT_W-1:0] cnt;
      logic [3:0] sum;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      dec = 7'h00;
      widx = 6'h00;
      rd = 8'h00;
      nxt = 5'h00;
      cnt = 16'h0000;
      sum = 4'h0;
      s_d = s_q;

      // per-packet sources cleared when the next packet goes out
      if (I_TX_START) begin
         s_d.pend.rx_pend = 1'b0;
         s_d.pend.col_pend = 1'b0;
         s_d.pend.part_pend = '0;
      end

      // write address and data gathered in either order
      aw_ok = s_q.aw_have;
      if (s_q.wr_st == WR_IDLE && !s_q.aw_have && I_AWVALID) begin
         dec = addr_decode(I_AWADDR);
         s_d.aw_idx = dec[5:0];
         s_d.aw_ok = dec[6];
         s_d.aw_have = 1'b1;
         aw_ok = 1'b1;
      end
      w_ok = s_q.w_have;
      if (s_q.wr_st == WR_IDLE && !s_q.w_have && I_WVALID) begin
         s_d.wdata = I_WDATA[7:0];
         s_d.wlane0 = I_WSTRB[0];
         s_d.w_have = 1'b1;
         w_ok = 1'b1;
      end

      // write performed once both halves are held
      case (s_q.wr_st)
         WR_IDLE: begin
            if (aw_ok && w_ok) begin
               widx = s_d.aw_idx;
               s_d.aw_have = 1'b0;
               s_d.w_have = 1'b0;
               s_d.wr_st = WR_RESP;
               s_d.bresp = RESP_DECERR;
               if (s_d.aw_ok && reg_hit(widx, s_q.page)) begin
                  s_d.bresp = RESP_OKAY;
                  if (s_d.wlane0) begin
                     if (widx == IDX_PAGE_AND_LOG_SUMMARY) begin
                        s_d.page = s_d.wdata[PAGE_SEL_LSB +: 3];
                     end else if (widx == IDX_LOWER_COUNT_ENABLES) begin
                        s_d.lower = s_d.wdata;
                     end else if (widx == IDX_UPPER_COUNT_ENABLES) begin
                        s_d.upper = s_d.wdata & UPPER_WRITABLE;
                     end
                     // revision and status ignore writes
                  end
               end
            end
         end
         WR_RESP: begin
            if (I_BREADY) begin
               s_d.wr_st = WR_IDLE;
            end
         end
         default: s_d.wr_st = WR_IDLE;
      endcase

      // read taken, answered next cycle
      case (s_q.rd_st)
         RD_IDLE: begin
            if (I_ARVALID) begin
               dec = addr_decode(I_ARADDR);
               s_d.rd_st = RD_RESP;
               s_d.rresp = RESP_DECERR;
               rd = 8'h00;
               if (dec[6] && reg_hit(dec[5:0], s_q.page)) begin
                  s_d.rresp = RESP_OKAY;
                  if (dec[5:0] == IDX_PKT_INT_STATUS) begin
                     rd = NO_VALID_INTERRUPT;
                     if (s_q.pend.rx_pend) begin
                        rd = status_byte(CAUSE_RECEIVE,
                                         s_q.pend.rx_port);
                        s_d.pend.rx_pend = 1'b0;
                     end else if (s_q.pend.col_pend) begin
                        rd = status_byte(CAUSE_FIRST_COLLISION,
                                         s_q.pend.col_port);
                        s_d.pend.col_pend = 1'b0;
                     end else if (rr_valid) begin
                        rd = status_byte(CAUSE_ISOLATION, rr_idx);
                        s_d.pend.part_pend[rr_idx] = 1'b0;
                        nxt = 5'(rr_idx) + 5'h01;
                        if (nxt >= 5'(NUM_PORTS)) begin
                           nxt = 5'h00;
                        end
                        s_d.pend.rr_ptr = nxt[3:0];
                     end
                  end else if (dec[5:0] == IDX_PAGE_AND_LOG_SUMMARY) begin
                     rd = {s_q.summary, 1'b0, s_q.page};
                  end else if (dec[5:0] == IDX_REVISION_CODE) begin
                     rd = REVISION;
                  end else if (dec[5:0] == IDX_LOWER_COUNT_ENABLES) begin
                     rd = s_q.lower;
                  end else begin
                     rd = s_q.upper;
                  end
               end
               s_d.rdata = rd;
            end
         end
         RD_RESP: begin
            if (I_RREADY) begin
               s_d.rd_st = RD_IDLE;
            end
         end
         default: s_d.rd_st = RD_IDLE;
      endcase

      // new events set after every clear, so they are never lost
      if (I_RX_EVENT && !I_RT_INT_DISABLE[RT_MASK_RECEIVE]) begin
         s_d.pend.rx_pend = 1'b1;
         s_d.pend.rx_port = I_RX_PORT;
      end
      if (I_FIRST_COL_EVENT && !I_RT_INT_DISABLE[RT_MASK_COLLISION]) begin
         s_d.pend.col_pend = 1'b1;
         s_d.pend.col_port = I_COL_PORT;
      end
      if (!I_RT_INT_DISABLE[RT_MASK_ISOLATION]) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (I_ISOLATION_EVENT[p]) begin
               s_d.pend.part_pend[p] = 1'b1;
            end
         end
      end

      // event log summary over all ports
      sum[SUM_FLAG_FOUND] = |I_PORT_FLAG_SET;
      for (int p = 0; p < NUM_PORTS; p++) begin
         cnt = I_EVENT_COUNT[p*COUNT_W +: COUNT_W];
         if (cnt < LOW_THRESHOLD) begin
            sum[SUM_LOW_COUNT] = 1'b1;
         end
         if (cnt > HIGH_THRESHOLD) begin
            sum[SUM_HIGH_COUNT] = 1'b1;
         end
         if (cnt == FULL_VALUE) begin
            sum[SUM_FULL_COUNTER] = 1'b1;
         end
      end
      s_d.summary = sum;
      s_d.event_log_interrupt_pin = |(sum & ~I_ELI_DISABLE);

      // collision count steps, out-of-window adds its own step
      s_d.col_inc = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         s_d.col_inc[2*p +: 2] =
            {1'b0, I_TX_COL[p] & s_q.upper[TX_COL_BIT]} +
            {1'b0, I_RX_COL[p] & s_q.upper[RX_COL_BIT]} +
            {1'b0, I_OWC[p] & s_q.upper[OWC_BIT]};
      end
   end

   // state register
   always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         s_q <= '{wr_st: WR_IDLE, rd_st: RD_IDLE, page: PAGE_RESET,
                  lower: LOWER_RESET, upper: UPPER_RESET,
                  pend: '0, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // bus handshakes
   assign O_AWREADY = (s_q.wr_st == WR_IDLE) && !s_q.aw_have;
   assign O_WREADY = (s_q.wr_st == WR_IDLE) && !s_q.w_have;
   assign O_BVALID = (s_q.wr_st == WR_RESP);
   assign O_BRESP = s_q.bresp;
   assign O_ARREADY = (s_q.rd_st == RD_IDLE);
   assign O_RVALID = (s_q.rd_st == RD_RESP);
   assign O_RDATA = {24'h000000, s_q.rdata};
   assign O_RRESP = s_q.rresp;

   // configuration and status towards the rest of the device
   assign O_PAGE_SEL = s_q.page;
   assign O_LOWER_COUNT_EN = s_q.lower;
   assign O_CLEAR_COUNTER_ON_READ = s_q.upper[CLEAR_ON_READ_BIT];
   assign O_STOP_COUNTER_AT_MAX = s_q.upper[STOP_AT_MAX_BIT];
   assign O_COL_COUNT_INC = s_q.col_inc[2*NUM_PORTS-1:0];
   assign O_PKT_INT_PENDING = s_q.pend.rx_pend | s_q.pend.col_pend |
                              (|part_req);
   assign O_EVENT_LOG_INTERRUPT_PIN = s_q.event_log_interrupt_pin;

endmodule

// ===== design/rtm_rr_pick.sv
`timescale 1ns/100ps
// picks the first requesting port at or after the rotation pointer
module rtm_rr_pick
   import rtm_pkg::*;
#(
   parameter int N = 13
) (
   // requests and rotation start
   input wire logic [N-1:0] i_req,
   input wire logic [3:0] i_ptr,
   // choice
   output logic o_valid,
   output logic [3:0] o_idx
);

   // refuse ring sizes the index cannot reach
   if (N < 1 || N > MAX_PORTS) begin : g_bad_size
      $error("rtm_rr_pick: N out of range");
   end

   // walk once around the ring starting at the pointer
   always_comb begin
      logic [4:0] cand;
      cand = 5'h00;
      o_valid = 1'b0;
      o_idx = 4'h0;
      for (int k = 0; k < N; k++) begin
         cand = 5'(i_ptr) + 5'(k);
         if (cand >= 5'(N)) begin
            cand = cand - 5'(N);
         end
         if (!o_valid && i_req[cand[3:0]]) begin
            o_valid = 1'b1;
            o_idx = cand[3:0];
         end
      end
   end

endmodule

// ===== sim/rtm_regs_props.sv
`timescale 1ns/100ps
module rtm_regs_props
   import rtm_pkg::*;
#(
   parameter int NUM_PORTS = 13
) (
   // clock and reset
   input wire logic I_MCLK,
   input wire logic I_ARST_N,
   // register bus
   input wire logic I_AWVALID,
   input wire logic O_AWREADY,
   input wire logic I_WVALID,
   input wire logic O_WREADY,
   input wire logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [1:0] O_BRESP,
   input wire logic I_ARVALID,
   input wire logic O_ARREADY,
   input wire logic [AXI_AW-1:0] I_ARADDR,
   input wire logic O_RVALID,
   input wire logic I_RREADY,
   input wire logic [31:0] O_RDATA,
   input wire logic [1:0] O_RRESP,
   // events and status
   input wire logic I_TX_START,
   input wire logic I_RX_EVENT,
   input wire logic I_FIRST_COL_EVENT,
   input wire logic [NUM_PORTS-1:0] I_ISOLATION_EVENT,
   input wire logic [2:0] I_RT_INT_DISABLE,
   input wire logic [NUM_PORTS-1:0] I_PORT_FLAG_SET,
   input wire logic [3:0] I_ELI_DISABLE,
   input wire logic O_PKT_INT_PENDING,
   input wire logic O_EVENT_LOG_INTERRUPT_PIN
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_ARST_N);

   // read walk steps
   sequence s_ar_take;
      I_ARVALID && O_ARREADY;
   endsequence
   sequence s_r_answer;
      O_RVALID && !O_ARREADY;
   endsequence

   a_rd_answer: assert property (s_ar_take |=> s_r_answer)
      else $error("read answer not one cycle after address");
   a_rd_hold: assert property (O_RVALID && !I_RREADY |=>
      O_RVALID && $stable(O_RDATA) && $stable(O_RRESP))
      else $error("read answer not held");
   a_wr_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID &&
      O_WREADY |=> O_BVALID && !O_AWREADY)
      else $error("write answer not one cycle after taking");
   a_b_hold: assert property (O_BVALID && !I_BREADY |=>
      O_BVALID && $stable(O_BRESP))
      else $error("write answer not held");
   a_empty_ff: assert property (
      s_ar_take and (I_ARADDR == 8'h3C && !O_PKT_INT_PENDING)
      |=> O_RDATA == 32'h000000FF)
      else $error("empty status read not all ones");
   a_tx_clear: assert property (
      I_TX_START && !I_RX_EVENT && !I_FIRST_COL_EVENT &&
      I_ISOLATION_EVENT == '0 |=> !O_PKT_INT_PENDING)
      else $error("transmit start left a source pending");
   a_rx_record: assert property (
      I_RX_EVENT && !I_RT_INT_DISABLE[2] |=> O_PKT_INT_PENDING)
      else $error("receive event not recorded");
   a_pin_flag: assert property (
      I_PORT_FLAG_SET != '0 && !I_ELI_DISABLE[0] |=>
      O_EVENT_LOG_INTERRUPT_PIN)
      else $error("flag found did not raise log pin");
   a_pin_off: assert property (
      &I_ELI_DISABLE |=> !O_EVENT_LOG_INTERRUPT_PIN)
      else $error("log pin high with all causes disabled");
endmodule

bind rtm_regs rtm_regs_props #(.NUM_PORTS(NUM_PORTS)) u_props (
   .I_MCLK, .I_ARST_N, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY,
   .O_BVALID, .I_BREADY, .O_BRESP, .I_ARVALID, .O_ARREADY, .I_ARADDR,
   .O_RVALID, .I_RREADY, .O_RDATA, .O_RRESP, .I_TX_START, .I_RX_EVENT,
   .I_FIRST_COL_EVENT, .I_ISOLATION_EVENT, .I_RT_INT_DISABLE,
   .I_PORT_FLAG_SET, .I_ELI_DISABLE, .O_PKT_INT_PENDING,
   .O_EVENT_LOG_INTERRUPT_PIN
);

// ===== sim/rtm_regs_tb_top.sv
`timescale 1ns/100ps
module rtm_regs_tb_top;
   import rtm_pkg::*;
   localparam int N = 13;
   localparam logic [7:0] REV = 8'h5A; // arbitrary value
   logic clk = 0, rst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0;
   logic rready = 0, txs = 0, rxe = 0, cole = 0;
   logic [7:0] awa = '0, ara = '0, v;
   logic [31:0] wd = '0, rdd;
   logic [3:0] rxp = '0, colp = '0, elid = '0;
   logic [2:0] rtd = '0, pg;
   logic [N-1:0] iso = '0, flg = '0, txc = '0, rxc = '0, owc = '0;
   logic [N*16-1:0] cnt = {N{16'h1000}};
   logic awr, wr_r, bv, arr, rv, cor, sam, pend, pin;
   logic [1:0] br, rr;
   logic [7:0] lo;
   logic [2*N-1:0] inc;
   logic [33:0] exp_r[$];
   logic [1:0] exp_b[$];
   logic [15:0] cv[5] = '{16'h0000, 16'h00FF, 16'hC000, 16'hC001, 16'hFFFF};
   logic [7:0] sv[5] = '{8'h20, 8'h00, 8'h00, 8'h40, 8'hC0};
   logic [7:0] um[4] = '{8'h38, 8'h20, 8'h18, 8'h00};
   logic [7:0] ue[4] = '{8'h03, 8'h01, 8'h02, 8'h00};
   int fails = 0, num_checks = 0;

   rtm_regs #(.NUM_PORTS(N), .REVISION(REV)) dut_u (
      .I_MCLK(clk), .I_ARST_N(rst_n), .I_AWVALID(awv), .O_AWREADY(awr),
      .I_AWADDR(awa), .I_AWPROT(3'h0), .I_WVALID(wv), .O_WREADY(wr_r),
      .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv), .I_BREADY(bready),
      .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
      .I_ARPROT(3'h0), .O_RVALID(rv), .I_RREADY(rready), .O_RDATA(rdd),
      .O_RRESP(rr), .I_TX_START(txs), .I_RX_EVENT(rxe), .I_RX_PORT(rxp),
      .I_FIRST_COL_EVENT(cole), .I_COL_PORT(colp),
      .I_ISOLATION_EVENT(iso), .I_RT_INT_DISABLE(rtd),
      .I_PORT_FLAG_SET(flg), .I_EVENT_COUNT(cnt), .I_ELI_DISABLE(elid),
      .I_TX_COL(txc), .I_RX_COL(rxc), .I_OWC(owc), .O_PAGE_SEL(pg),
      .O_LOWER_COUNT_EN(lo), .O_CLEAR_COUNTER_ON_READ(cor),
      .O_STOP_COUNTER_AT_MAX(sam), .O_COL_COUNT_INC(inc),
      .O_PKT_INT_PENDING(pend), .O_EVENT_LOG_INTERRUPT_PIN(pin)
   );

   // clock
   initial begin
      forever #20 clk = ~clk;
   end

   task automatic note(input logic ok, input string m);
      num_checks++;
      if (!ok) begin
         fails++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e,
                      input string m);
      note(g === e, m);
   endtask

   task automatic cmp_rd(input logic [33:0] g);
      note(exp_r.size() > 0 && g === exp_r.pop_front(), "read data");
   endtask

   task automatic cmp_b(input logic [1:0] g);
      note(exp_b.size() > 0 && g === exp_b.pop_front(), "write resp");
   endtask

   // bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] r);
      bit done = 0;
      exp_b.push_back(r);
      @(posedge clk);
      awv <= 1;
      wv <= 1;
      awa <= a;
      wd <= {24'h0, d};
      bready <= 1;
      for (int i = 0; i < 100 && !done; i++) begin
         @(posedge clk);
         if (awv && awr) awv <= 0;
         if (wv && wr_r) wv <= 0;
         if (bv) begin
            bready <= 0;
            done = 1;
         end
      end
      if (!done) begin
         note(0, "write timeout");
         give_verdict();
      end
   endtask

   // bus read
   task automatic rd(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] r);
      bit done = 0;
      exp_r.push_back({r, 24'h0, d});
      @(posedge clk);
      arv <= 1;
      ara <= a;
      rready <= 1;
      for (int i = 0; i < 100 && !done; i++) begin
         @(posedge clk);
         if (arv && arr) arv <= 0;
         if (rv) begin
            rready <= 0;
            done = 1;
         end
      end
      if (!done) begin
         note(0, "read timeout");
         give_verdict();
      end
   endtask

   // one-cycle event pulses
   task automatic ev(input logic r, input logic c, input logic t,
                     input logic [N-1:0] s);
      @(posedge clk);
      rxe <= r;
      cole <= c;
      txs <= t;
      iso <= s;
      @(posedge clk);
      {rxe, cole, txs} <= 3'h0;
      iso <= '0;
   endtask

   // results leaving the bus
   always @(posedge clk) begin
      if (rv && rready) cmp_rd({rr, rdd});
      if (bv && bready) cmp_b(br);
   end

   initial begin
      void'($urandom(32'h0EDB));
      repeat (12) @(posedge clk);
      rst_n <= 1;
      rd(8'h48, 8'h00, RESP_OKAY);
      rd(8'h40, 8'h00, RESP_OKAY);
      wr(8'h44, 8'hFF, RESP_OKAY);
      rd(8'h44, REV, RESP_OKAY);
      rd(8'h50, 8'h00, RESP_DECERR);
      wr(8'h41, 8'h01, RESP_DECERR);
      $display("test reset and decode done");
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom);
         wr(8'h48, v, RESP_OKAY);
         rd(8'h48, v, RESP_OKAY);
         chk(lo, v, "lower enables");
      end
      wr(8'h4C, 8'hFF, RESP_OKAY);
      rd(8'h4C, 8'h3B, RESP_OKAY);
      chk({6'h0, cor, sam}, 8'h03, "upper controls");
      wr(8'h4C, 8'h02, RESP_OKAY);
      chk({6'h0, cor, sam}, 8'h01, "upper controls");
      wr(8'h40, 8'h05, RESP_OKAY);
      chk({5'h0, pg}, 8'h05, "page out");
      rd(8'h40, 8'h05, RESP_OKAY);
      rd(8'h44, 8'h00, RESP_DECERR);
      wr(8'h40, 8'h00, RESP_OKAY);
      $display("test masks and page done");
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         cnt[6*16 +: 16] <= cv[i];
         rd(8'h40, sv[i], RESP_OKAY);
         chk({7'h0, pin}, {7'h0, |sv[i]}, "log pin");
      end
      cnt[6*16 +: 16] <= 16'h1000;
      flg[9] <= 1;
      rd(8'h40, 8'h10, RESP_OKAY);
      chk({7'h0, pin}, 8'h01, "log pin flag");
      elid <= 4'h1;
      rd(8'h40, 8'h10, RESP_OKAY);
      chk({7'h0, pin}, 8'h00, "log pin masked");
      elid <= 4'hF;
      flg <= '0;
      $display("test summary done");
      rxp <= 4'h3;
      colp <= 4'h5;
      ev(1, 1, 0, 13'h0084);
      rd(8'h3C, 8'h3B, RESP_OKAY);
      chk({7'h0, pend}, 8'h01, "others still pending");
      rd(8'h3C, 8'h5D, RESP_OKAY);
      rd(8'h3C, 8'h27, RESP_OKAY);
      rd(8'h3C, 8'h77, RESP_OKAY);
      chk({7'h0, pend}, 8'h00, "all sources cleared");
      rd(8'h3C, 8'hFF, RESP_OKAY);
      ev(0, 0, 0, 13'h0012);
      rd(8'h3C, 8'h17, RESP_OKAY);
      rd(8'h3C, 8'h47, RESP_OKAY);
      ev(1, 1, 0, 13'h0001);
      ev(0, 0, 1, '0);
      rd(8'h3C, 8'hFF, RESP_OKAY);
      rtd <= 3'h7;
      ev(1, 1, 0, '1);
      rd(8'h3C, 8'hFF, RESP_OKAY);
      rtd <= 3'h0;
      $display("test status done");
      for (int i = 0; i < 4; i++) begin
         wr(8'h4C, um[i], RESP_OKAY);
         @(posedge clk);
         {txc[0], rxc[0], owc[0]} <= 3'h7;
         @(posedge clk);
         {txc[0], rxc[0], owc[0]} <= 3'h0;
         @(negedge clk);
         chk({6'h0, inc[1:0]}, ue[i], "collision step");
      end
      $display("test collision counts done");
      give_verdict();
   end
endmodule
